/* nvmc_pkg.sv */
// ****************************************************************
// nvm unlock and eeprom write control: shared constants
// ****************************************************************
package nvmc_pkg;

   // register indices; the byte address is four times the index
   localparam logic [11:0] NVMC_IDX_CONTROL  = 12'h760;  // control and status bits
   localparam logic [11:0] NVMC_IDX_ADR_LOW  = 12'h762;  // address bits 15:0
   localparam logic [11:0] NVMC_IDX_ADR_UP   = 12'h764;  // address bits 23:16
   localparam logic [11:0] NVMC_IDX_KEY      = 12'h766;  // write-only unlock key
   localparam logic [11:0] NVMC_IDX_STATUS   = 12'h768;  // done flag, write one to clear

   // control register fields
   localparam int          NVMC_BIT_WR       = 15;       // start / busy
   localparam int          NVMC_BIT_WRITE_ENABLE_BIT     = 14;       // write enable
   localparam int          NVMC_BIT_WRITE_ERROR_FLAG    = 13;       // write error
   localparam int          NVMC_BIT_WRITE_INTERRUPT_CONTROL     = 8;        // write interrupt control
   localparam int          NVMC_OP_W         = 7;        // operation select width
   localparam int          NVMC_BIT_DONE     = 0;        // status: done flag

   // reset values
   localparam logic [15:0] NVMC_CTRL_RST     = 16'h0000;
   localparam logic [15:0] NVMC_ADR_RST      = 16'h0000;

   // unlock keys
   localparam logic [7:0]  NVMC_KEY_FIRST    = 8'h55;
   localparam logic [7:0]  NVMC_KEY_SECOND   = 8'hAA;

   // eeprom window in program space
   localparam logic [23:0] NVMC_EE_LO        = 24'h7FF000;
   localparam logic [23:0] NVMC_EE_HI        = 24'h7FFFFE;

   // operation codes of interest
   localparam logic [6:0]  NVMC_OP_BLK_ERASE = 7'h45;
   localparam logic [6:0]  NVMC_OP_WRD_ERASE = 7'h44;

   // unlock sequence states
   typedef enum logic [2:0]
   {
      NVMC_KS_IDLE  = 3'b001,
      NVMC_KS_GOT55 = 3'b010,
      NVMC_KS_ARMED = 3'b100
   } nvmc_key_e;

endpackage : nvmc_pkg

/* nvmc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module nvmc_ctrl
(
   input  wire logic        hclk,            // system clock, 40 MHz
   input  wire logic        hresetn,         // power-up reset
   input  wire logic        hsel,            // ahb slave select
   input  wire logic [31:0] haddr,           // ahb address
   input  wire logic [1:0]  htrans,          // ahb transfer type
   input  wire logic        hwrite,          // ahb direction
   input  wire logic [2:0]  hsize,           // ahb size, word only
   input  wire logic [31:0] hwdata,          // ahb write data
   input  wire logic        hready,          // ahb bus ready
   output var  logic        hreadyout,       // ahb slave ready
   output var  logic        hresp,           // ahb response
   output var  logic [31:0] hrdata,          // ahb read data
   input  wire logic        tbl_valid,       // table instruction executed
   input  wire logic        tbl_write,       // table instruction is a write
   input  wire logic [23:0] tbl_ea,          // its effective address
   input  wire logic        warm_reset_req,  // master reset or watchdog, async
   input  wire logic        cell_done,       // array reports cycle finished
   output var  logic        cell_start,      // one-cycle start to array
   output var  logic        cell_abort,      // one-cycle abort to array
   output var  logic [6:0]  cell_op,         // operation held for array
   output var  logic [23:0] cell_addr,       // address held for array
   output var  logic        nvm_done_flag,   // sticky done flag
   output var  logic        nvm_busy,        // cycle in progress
   output var  logic        ee_sel,          // table access of the previous cycle hit eeprom
   output var  logic        ee_rd_unspec     // that read returned undefined data
);

   // ****************************************************************
   // bus address and data phase
   // ****************************************************************
   logic        ph_wr_r;      // write data phase pending
   logic [11:0] ph_idx_r;     // latched register index
   logic        ph_map_r;     // latched address lies in our page
   logic [31:0] hrdata_r;     // registered read data
   logic        hreadyout_r;  // ready from the edge after reset release: we never stall the core

   wire         a_take = hsel & htrans[1] & hready;
   wire         a_map  = (haddr[31:14] == 18'h00000);
   wire  [11:0] a_idx  = haddr[13:2];
   wire         a_rd   = a_take & ~hwrite;

   // decoded write strobes, valid in the data phase
   wire         w_any  = ph_wr_r;
   wire         w_ctrl = ph_wr_r & ph_map_r & (ph_idx_r == nvmc_pkg::NVMC_IDX_CONTROL);
   wire         w_lo   = ph_wr_r & ph_map_r & (ph_idx_r == nvmc_pkg::NVMC_IDX_ADR_LOW);
   wire         w_up   = ph_wr_r & ph_map_r & (ph_idx_r == nvmc_pkg::NVMC_IDX_ADR_UP);
   wire         w_key  = ph_wr_r & ph_map_r & (ph_idx_r == nvmc_pkg::NVMC_IDX_KEY);
   wire         w_stat = ph_wr_r & ph_map_r & (ph_idx_r == nvmc_pkg::NVMC_IDX_STATUS);

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_wr_r     <= 1'b0;
         ph_idx_r    <= 12'h000;
         ph_map_r    <= 1'b0;
         hreadyout_r <= 1'b0;
      end
      else
      begin
         ph_wr_r     <= a_take & hwrite;
         ph_idx_r    <= a_idx;
         ph_map_r    <= a_map;
         hreadyout_r <= 1'b1;
      end
   end

   // ****************************************************************
   // warm reset synchroniser
   // ****************************************************************
   logic warm_m_r;  // first stage, read only by the second
   logic warm_s_r;  // synchronised level

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         warm_m_r <= 1'b0;
         warm_s_r <= 1'b0;
      end
      else
      begin
         warm_m_r <= warm_reset_req;
         warm_s_r <= warm_m_r;
      end
   end

   // ****************************************************************
   // unlock sequence
   // ****************************************************************
   nvmc_pkg::nvmc_key_e key_r;    // unlock state
   nvmc_pkg::nvmc_key_e key_nxt;

   wire key55 = w_key & (hwdata[7:0] == nvmc_pkg::NVMC_KEY_FIRST);
   wire keyaa = w_key & (hwdata[7:0] == nvmc_pkg::NVMC_KEY_SECOND);
   // only bus writes and table accesses are visible as instructions
   wire instr = w_any | tbl_valid;

   always_comb
   begin
      key_nxt = key_r;
      case (key_r)
         nvmc_pkg::NVMC_KS_IDLE:
         begin
            if (key55 & ~tbl_valid)
               key_nxt = nvmc_pkg::NVMC_KS_GOT55;
         end
         nvmc_pkg::NVMC_KS_GOT55:
         begin
            if (keyaa & ~tbl_valid)
               key_nxt = nvmc_pkg::NVMC_KS_ARMED;
            else if (key55 & ~tbl_valid)
               key_nxt = nvmc_pkg::NVMC_KS_GOT55;
            else if (instr)
               key_nxt = nvmc_pkg::NVMC_KS_IDLE;
         end
         nvmc_pkg::NVMC_KS_ARMED:
         begin
            // any instruction, the start write included, spends the arming
            if (instr)
               key_nxt = nvmc_pkg::NVMC_KS_IDLE;
         end
         default:
            key_nxt = nvmc_pkg::NVMC_KS_IDLE;
      endcase
      if (warm_s_r)
         key_nxt = nvmc_pkg::NVMC_KS_IDLE;
   end

   // unlock state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         key_r <= nvmc_pkg::NVMC_KS_IDLE;
      else
         key_r <= key_nxt;
   end

   // ****************************************************************
   // control register and write cycle
   // ****************************************************************
   logic       wr_r;     // start / busy bit
   logic       write_enable_bit_r;   // write enable
   logic       err_r;    // write error flag
   logic       write_interrupt_control_r;   // write interrupt control
   logic [6:0] op_r;     // operation select
   logic       done_r;   // sticky completion flag
   logic       wr_nxt;
   logic       err_nxt;
   logic       done_nxt;

   wire start_req = w_ctrl & hwdata[nvmc_pkg::NVMC_BIT_WR] & ~tbl_valid
                  & (key_r == nvmc_pkg::NVMC_KS_ARMED) & write_enable_bit_r & ~wr_r & ~warm_s_r;
   wire finish    = wr_r & cell_done & ~warm_s_r;
   wire broken    = wr_r & warm_s_r;

   // next values of the set/clear bits
   always_comb
   begin
      // software can only set; hardware clears
      wr_nxt = wr_r;
      if (warm_s_r | finish)
         wr_nxt = 1'b0;
      else if (start_req)
         wr_nxt = 1'b1;
      // set wins over a software clear
      err_nxt = err_r;
      if (w_ctrl)
         err_nxt = hwdata[nvmc_pkg::NVMC_BIT_WRITE_ERROR_FLAG];
      if (broken)
         err_nxt = 1'b1;
      // done sticks until cleared, set wins
      done_nxt = done_r;
      if (w_stat & hwdata[nvmc_pkg::NVMC_BIT_DONE])
         done_nxt = 1'b0;
      if (finish)
         done_nxt = 1'b1;
   end

   // control bits; enable cleared at power-up
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_r   <= nvmc_pkg::NVMC_CTRL_RST[nvmc_pkg::NVMC_BIT_WR];
         write_enable_bit_r <= nvmc_pkg::NVMC_CTRL_RST[nvmc_pkg::NVMC_BIT_WRITE_ENABLE_BIT];
         err_r  <= nvmc_pkg::NVMC_CTRL_RST[nvmc_pkg::NVMC_BIT_WRITE_ERROR_FLAG];
         write_interrupt_control_r <= nvmc_pkg::NVMC_CTRL_RST[nvmc_pkg::NVMC_BIT_WRITE_INTERRUPT_CONTROL];
         op_r   <= nvmc_pkg::NVMC_CTRL_RST[6:0];
         done_r <= 1'b0;
      end
      else
      begin
         wr_r   <= wr_nxt;
         err_r  <= err_nxt;
         done_r <= done_nxt;
         if (warm_s_r)
         begin
            // device reset clears control but not error or address
            write_enable_bit_r <= 1'b0;
            write_interrupt_control_r <= 1'b0;
            op_r   <= 7'h00;
         end
         else if (w_ctrl)
         begin
            // enable may drop without touching the cycle
            write_enable_bit_r <= hwdata[nvmc_pkg::NVMC_BIT_WRITE_ENABLE_BIT];
            // op frozen while busy so the array sees a steady command
            if (!wr_r)
            begin
               write_interrupt_control_r <= hwdata[nvmc_pkg::NVMC_BIT_WRITE_INTERRUPT_CONTROL];
               op_r   <= hwdata[6:0];
            end
         end
      end
   end

   // ****************************************************************
   // address capture
   // ****************************************************************
   logic [15:0] adr_lo_r;  // address low
   logic [7:0]  adr_up_r;  // upper address field

   // table access wins over a software write in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         adr_lo_r <= nvmc_pkg::NVMC_ADR_RST;
         adr_up_r <= nvmc_pkg::NVMC_ADR_RST[7:0];
      end
      else if (tbl_valid)
      begin
         adr_lo_r <= tbl_ea[15:0];
         adr_up_r <= tbl_ea[23:16];
      end
      else
      begin
         if (w_lo)
            adr_lo_r <= hwdata[15:0];
         if (w_up)
            adr_up_r <= hwdata[7:0];
      end
   end

   // ****************************************************************
   // array side and eeprom steering
   // ****************************************************************
   logic        start_o_r;  // start pulse
   logic        abort_o_r;  // abort pulse
   logic [6:0]  op_o_r;     // held operation
   logic [23:0] addr_o_r;   // held address, word or 16-word block base
   logic        ee_sel_r;   // table access in eeprom window
   logic        ee_uns_r;   // that access read during a cycle

   wire in_ee = (tbl_ea >= nvmc_pkg::NVMC_EE_LO) & (tbl_ea <= nvmc_pkg::NVMC_EE_HI);

   // array command and steering flags
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         start_o_r <= 1'b0;
         abort_o_r <= 1'b0;
         op_o_r    <= 7'h00;
         addr_o_r  <= 24'h000000;
         ee_sel_r  <= 1'b0;
         ee_uns_r  <= 1'b0;
      end
      else
      begin
         start_o_r <= start_req;
         abort_o_r <= broken;
         if (start_req)
         begin
            op_o_r   <= op_r;
            addr_o_r <= {adr_up_r, adr_lo_r};
         end
         ee_sel_r <= tbl_valid & in_ee;
         // flag only; the data itself is not defined
         ee_uns_r <= tbl_valid & in_ee & ~tbl_write & wr_r;
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   // key reads zero; unmapped reads zero
   wire [15:0] ctrl_v = {wr_r, write_enable_bit_r, err_r, 4'h0, write_interrupt_control_r, 1'b0, op_r};
   wire [15:0] rd_v   = ~a_map ? 16'h0000 :
                        (a_idx == nvmc_pkg::NVMC_IDX_CONTROL) ? ctrl_v :
                        (a_idx == nvmc_pkg::NVMC_IDX_ADR_LOW) ? adr_lo_r :
                        (a_idx == nvmc_pkg::NVMC_IDX_ADR_UP)  ? {8'h00, adr_up_r} :
                        (a_idx == nvmc_pkg::NVMC_IDX_STATUS)  ? {15'h0000, done_r} : 16'h0000;

   // sampled at the address phase; a write just before is not forwarded
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (a_rd)
         hrdata_r <= {16'h0000, rd_v};
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // low through reset and the release edge, then always ready, never a wait state
   assign hreadyout     = hreadyout_r;
   assign hresp         = 1'b0;
   assign hrdata        = hrdata_r;
   assign cell_start    = start_o_r;
   assign cell_abort    = abort_o_r;
   assign cell_op       = op_o_r;
   assign cell_addr     = addr_o_r;
   assign nvm_done_flag = done_r;
   assign nvm_busy      = wr_r;
   assign ee_sel        = ee_sel_r;
   assign ee_rd_unspec  = ee_uns_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_KEY_GATE: assert property (!wr_r && key_r != nvmc_pkg::NVMC_KS_ARMED |=> !wr_r)
      else $error("start taken without unlock");
   // sampled reset guards the release edge, where the ready flop is still low
   AST_NO_STALL: assert property (hresetn |=> hreadyout)
      else $error("slave inserted a wait state");
   AST_HOLD_BUSY: assert property (wr_r && !cell_done && !warm_s_r |=> wr_r)
      else $error("start bit dropped before completion");
   AST_DONE_SET: assert property (wr_r && cell_done && !warm_s_r |=> !wr_r && nvm_done_flag)
      else $error("completion did not clear start and set done");
   AST_WRITE_ENABLE_BIT_HOLD: assert property (!w_ctrl && !warm_s_r |=> $stable(write_enable_bit_r))
      else $error("enable changed without software");
   AST_OP_LOCK: assert property (wr_r && !warm_s_r |=> $stable(op_r))
      else $error("operation changed during cycle");
   AST_WRITE_ENABLE_BIT_FIRST: assert property (w_ctrl && !write_enable_bit_r && !wr_r |=> !wr_r)
      else $error("start set together with enable");
   AST_RST_ERR: assert property (wr_r && warm_s_r && !tbl_valid && !w_lo |=> err_r && !wr_r
                                 && $stable(adr_lo_r) && cell_abort)
      else $error("interrupted cycle not flagged");
   AST_EE_STEER: assert property (tbl_valid && in_ee |=> ee_sel)
      else $error("eeprom access not steered");
   AST_CAPTURE: assert property (tbl_valid |=> {adr_up_r, adr_lo_r} == $past(tbl_ea))
      else $error("address not captured");
   AST_CANCEL: assert property (key_r == nvmc_pkg::NVMC_KS_ARMED && tbl_valid |=> key_r == nvmc_pkg::NVMC_KS_IDLE)
      else $error("unlock not cancelled");

   COV_BLK: cover property (start_req && op_r == nvmc_pkg::NVMC_OP_BLK_ERASE);
   COV_WRD: cover property (start_req && op_r == nvmc_pkg::NVMC_OP_WRD_ERASE);
   COV_DONE: cover property (cell_start ##[1:20] finish);
   COV_ERR: cover property (broken);

endmodule : nvmc_ctrl

`default_nettype wire

/* nvmc_cell_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// nvm cell array stand-in: answers a start after a set delay
// ****************************************************************
module nvmc_cell_model
(
   input  wire logic        hclk,        // system clock
   input  wire logic        hresetn,     // async reset, active low
   input  wire logic        cell_start,  // start pulse from controller
   input  wire logic        cell_abort,  // abort pulse from controller
   input  wire logic [15:0] dly,         // cycles to finish, bench sets
   output var  logic        cell_done    // one-cycle finish pulse
);

   logic [15:0] cnt_r;  // cycles left, zero when idle

   // cycle length varies
   // the bench picks prompt or slow, so no fixed count can pass
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r     <= 16'h0000;
         cell_done <= 1'b0;
      end
      else
      begin
         // an aborted cycle must never report done
         if (cell_abort)
            cnt_r <= 16'h0000;
         else if (cell_start)
            cnt_r <= dly;
         else if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
         cell_done <= (cnt_r == 16'h0001) && !cell_abort;
      end
   end

endmodule : nvmc_cell_model

`default_nettype wire

/* test_nvm_unlock_and_eeprom_write_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_nvm_unlock_and_eeprom_write_control;

   // ****************************************************************
   // signals
   // ****************************************************************
   localparam logic [11:0] IX_CTL = nvmc_pkg::NVMC_IDX_CONTROL;  // control
   localparam logic [11:0] IX_LO  = nvmc_pkg::NVMC_IDX_ADR_LOW;  // address low
   localparam logic [11:0] IX_UP  = nvmc_pkg::NVMC_IDX_ADR_UP;   // address upper
   localparam logic [11:0] IX_KEY = nvmc_pkg::NVMC_IDX_KEY;      // unlock key
   localparam logic [11:0] IX_ST  = nvmc_pkg::NVMC_IDX_STATUS;   // done status

   logic        hclk           = 1'b0;    // 40 MHz
   logic        hresetn        = 1'b0;    // async reset, low
   logic        hsel           = 1'b0;    // slave select
   logic [31:0] haddr          = 32'h0;   // byte address
   logic [1:0]  htrans         = 2'b00;   // idle at rest
   logic        hwrite         = 1'b0;    // direction
   logic [2:0]  hsize          = 3'b010;  // word only
   logic [31:0] hwdata         = 32'h0;   // write data
   logic        tbl_valid      = 1'b0;    // table access strobe
   logic        tbl_write      = 1'b0;    // table write
   logic [23:0] tbl_ea         = 24'h0;   // table address
   logic        warm_reset_req = 1'b0;    // master reset or watchdog
   logic [15:0] dly            = 16'h1;   // array delay
   logic        seen_abort     = 1'b0;    // sticky abort seen
   wire logic   hreadyout;                // slave ready, also hready
   wire logic   hresp;                    // response
   wire logic [31:0] hrdata;              // read data
   wire logic   cell_done;                // array finish
   wire logic   cell_start;               // array start
   wire logic   cell_abort;               // array abort
   wire logic [6:0]  cell_op;             // latched operation
   wire logic [23:0] cell_addr;           // latched address
   wire logic   nvm_done_flag;            // sticky done
   wire logic   nvm_busy;                 // cycle running
   wire logic   ee_sel;                   // eeprom hit
   wire logic   ee_rd_unspec;             // read while busy
   int          n_fail         = 0;       // mismatches
   int          checks_done    = 0;       // comparisons

   // free-running clock, 25 ns
   always #12.5 hclk = ~hclk;

   // abort is one cycle wide, so latch it for later
   always @(posedge hclk)
      if (cell_abort === 1'b1)
         seen_abort <= 1'b1;

   nvmc_ctrl i_dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
      .tbl_ea(tbl_ea), .warm_reset_req(warm_reset_req),
      .cell_done(cell_done), .cell_start(cell_start),
      .cell_abort(cell_abort), .cell_op(cell_op), .cell_addr(cell_addr),
      .nvm_done_flag(nvm_done_flag), .nvm_busy(nvm_busy),
      .ee_sel(ee_sel), .ee_rd_unspec(ee_rd_unspec)
   );

   nvmc_cell_model i_cell
   (
      .hclk(hclk), .hresetn(hresetn), .cell_start(cell_start),
      .cell_abort(cell_abort), .dly(dly), .cell_done(cell_done)
   );

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   // one compare for every result kind
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // single ahb transfer; held until hready, read data at second edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      // align to a rising edge: callers may return a little after one
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] ix, input logic [15:0] d);
      logic [31:0] rd_v;
      bus(1'b1, {18'h00000, ix, 2'b00}, {16'h0000, d}, rd_v);
   endtask : wr

   task automatic rchk(input string nm, input logic [11:0] ix, input logic [15:0] exp);
      logic [31:0] rd_v;
      bus(1'b0, {18'h00000, ix, 2'b00}, 32'h0, rd_v);
      chk(nm, {16'h0000, exp}, rd_v);
   endtask : rchk

   // key writes kept back to back, nothing between
   task automatic unlock();
      wr(IX_KEY, {8'h00, nvmc_pkg::NVMC_KEY_FIRST});
      wr(IX_KEY, {8'h00, nvmc_pkg::NVMC_KEY_SECOND});
   endtask : unlock

   // set mode with enable, unlock, then start; returns just after
   task automatic arm(input logic [15:0] c);
      wr(IX_CTL, c);
      unlock();
      wr(IX_CTL, c | 16'h8000);
      #1;
   endtask : arm

   // one table access pulse, result visible on return
   task automatic tbl(input logic w, input logic [23:0] ea);
      // drive on a rising edge, never between edges
      @(posedge hclk);
      tbl_valid <= 1'b1;
      tbl_write <= w;
      tbl_ea    <= ea;
      @(posedge hclk);
      tbl_valid <= 1'b0;
      #1;
   endtask : tbl

   // software waits on the flag before the next cycle
   task automatic wait_done();
      for (int i = 0; i < 400 && nvm_done_flag !== 1'b1; i++)
      begin
         @(posedge hclk);
         #1;
      end
      chk("done flag", 1, nvm_done_flag);
      chk("busy", 0, nvm_busy);
   endtask : wait_done

   task automatic no_start();
      wr(IX_CTL, 16'hC044);
      #1;
      chk("busy", 0, nvm_busy);
   endtask : no_start

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      logic [31:0] rd_v;
      rchk("control", IX_CTL, 16'h0000);
      rchk("key", IX_KEY, 16'h0000);
      // unmapped: upper address bits set
      bus(1'b1, 32'h0000_5D80, 32'h0000_4044, rd_v);
      bus(1'b0, 32'h0000_5D80, 32'h0, rd_v);
      chk("unmapped", 32'h0, rd_v);
      rchk("control", IX_CTL, 16'h0000);
      chk("hresp", 0, hresp);
   endtask : t_reset

   task automatic t_refuse();
      wr(IX_CTL, 16'h0044);
      unlock();
      no_start();
      no_start();
      wr(IX_KEY, 16'h00AA);
      wr(IX_KEY, 16'h0055);
      no_start();
      wr(IX_KEY, 16'h0055);
      wr(IX_LO, 16'h0000);
      wr(IX_KEY, 16'h00AA);
      no_start();
      unlock();
      tbl(1'b1, 24'h000000);
      no_start();
      chk("start pulse", 0, cell_start);
   endtask : t_refuse

   task automatic t_word();
      dly <= 16'h0001;
      wr(IX_CTL, 16'h4044);
      wr(IX_KEY, 16'h0055);
      rchk("control", IX_CTL, 16'h4044);
      wr(IX_KEY, 16'h00AA);
      wr(IX_CTL, 16'hC044);
      #1;
      chk("start pulse", 1, cell_start);
      chk("busy", 1, nvm_busy);
      chk("op", 7'h44, cell_op);
      wait_done();
      rchk("control", IX_CTL, 16'h4044);
      rchk("status", IX_ST, 16'h0001);
      wr(IX_ST, 16'h0001);
      rchk("status", IX_ST, 16'h0000);
   endtask : t_word

   task automatic t_block();
      dly <= 16'h0050;
      wr(IX_UP, 16'h007F);
      wr(IX_LO, 16'hF020);
      // block erase, enable dropped right after start
      arm(16'h4045);
      chk("busy", 1, nvm_busy);
      chk("op", 7'h45, cell_op);
      chk("address", 24'h7FF020, cell_addr);
      wr(IX_CTL, 16'h0045);
      #1;
      chk("busy", 1, nvm_busy);
      chk("hready", 1, hreadyout);
      tbl(1'b0, 24'h7FF000);
      chk("eeprom select", 1, ee_sel);
      chk("read undefined", 1, ee_rd_unspec);
      chk("busy", 1, nvm_busy);
      wait_done();
      rchk("control", IX_CTL, 16'h0045);
      wr(IX_ST, 16'h0001);
   endtask : t_block

   task automatic t_table();
      tbl(1'b1, 24'h7FEFFE);
      chk("eeprom select", 0, ee_sel);
      rchk("address low", IX_LO, 16'hEFFE);
      tbl(1'b0, 24'h7FFFFE);
      chk("eeprom select", 1, ee_sel);
      chk("read undefined", 0, ee_rd_unspec);
      rchk("address upper", IX_UP, 16'h007F);
      rchk("address low", IX_LO, 16'hFFFE);
   endtask : t_table

   task automatic t_warm();
      dly <= 16'h00C8;
      wr(IX_LO, 16'hF040);
      arm(16'h4045);
      chk("busy", 1, nvm_busy);
      @(posedge hclk);
      warm_reset_req <= 1'b1;
      repeat (4) @(posedge hclk);
      warm_reset_req <= 1'b0;
      repeat (4) @(posedge hclk);
      #1;
      chk("busy", 0, nvm_busy);
      chk("abort seen", 1, seen_abort);
      chk("done flag", 0, nvm_done_flag);
      rchk("control", IX_CTL, 16'h2000);
      rchk("address low", IX_LO, 16'hF040);
      rchk("address upper", IX_UP, 16'h007F);
   endtask : t_warm

   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // watchdog: whole run needs about three hundred cycles
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      conclude();
   end

   // main sequence
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_refuse();
      t_word();
      t_block();
      t_table();
      t_warm();
      conclude();
   end

endmodule : test_nvm_unlock_and_eeprom_write_control

`default_nettype wire
